// file: dta_pkg.sv
// shared constants and types for the dram timing and arbitration block
// assumes a single clock domain and a synchronous active-high reset
`default_nettype none

package dta_pkg;

	// bank and refresh-row geometry
	localparam int DTA_BANKS         = 4;
	localparam int DTA_BANK_W        = 2;
	localparam int DTA_REFRESH_ROW_W = 10;

	// reset value of the pending-refresh flag
	localparam logic DTA_PENDING_RESET = 1'h0;

	// cycle sequencer states; the comment gives the documented state number
	typedef enum logic [3:0]
	{
		DTA_IDLE,        // 0
		DTA_ROW,         // 1
		DTA_COL,         // 2
		DTA_COL_HOLD,    // 2, extra clock
		DTA_ACCESS,      // 4
		DTA_RMW_WAIT,    // read-modify-write extension
		DTA_PRECHARGE,   // row strobe released
		DTA_REF_ADDR,    // 16
		DTA_REF_STROBE,  // 17
		DTA_REF_END      // row strobe and refresh select released
	} dta_state_t;

	// control lines toward the memory array and the data-sizing chip
	typedef struct packed
	{
		logic [DTA_BANKS-1:0] row_strobe;
		logic                 row_address_enable;
		logic                 column_address_enable;
		logic                 cycle_sync;
		logic                 refresh_address_select;
	} dta_dram_ctl_t;

	localparam dta_dram_ctl_t DTA_CTL_RESET = '{
		row_strobe:             4'h0,
		row_address_enable:     1'h1,
		column_address_enable:  1'h0,
		cycle_sync:             1'h0,
		refresh_address_select: 1'h0
	};

endpackage

`default_nettype wire

// file: dta_refresh_flag.sv
// pending-refresh flag: a small independent state machine
// assumes the request pulse is at most one clock and synchronous to i_clock
`timescale 1ns/100ps
`default_nettype none

module dta_refresh_flag
(
	// clock and reset
	input  wire logic i_clock,
	input  wire logic i_rst,
	// events
	input  wire logic i_refresh_request,
	input  wire logic i_refresh_taken,
	// flag
	output var  logic o_refresh_pending_flag
);

	logic flag_reg;
	logic flag_next;

	always_comb
	begin
		flag_next = flag_reg;
		if (i_refresh_taken)
			flag_next = 1'h0;
		// a request in the clearing cycle is kept: set wins
		if (i_refresh_request)
			flag_next = 1'h1;
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			flag_reg <= dta_pkg::DTA_PENDING_RESET;
		else
			flag_reg <= flag_next;
	end

	assign o_refresh_pending_flag = flag_reg;

endmodule

`default_nettype wire

// file: dta_timing_arbiter.sv
// timing and arbitration sequencer for a four-bank dynamic ram array
// assumes requests are synchronous to i_clock and that an outside
// counter supplies the refresh row while refresh_address_select is high
//
// Function
// - the running cycle wins first, then a pending refresh, then a processor request.
// - arbitration only happens in idle state 0, and refresh requests arriving meanwhile are stored.
// - a one-clock refresh request sets a pending flag that holds until its refresh runs, then clears.
// - refresh cycles raise refresh_address_select so the refresh row drives the address bus.
// - state 16 drops row_address_enable and selects refresh, state 17 strobes all banks, then both release.
// - idle with no refresh pending and memory_request high starts a processor cycle in state 1; with neither, it stays idle.
// - a processor cycle strobes exactly one bank, picked by the two bank_select inputs.
// - state 2 drops row_address_enable, raises column_address_enable and raises cycle_sync.
// - state 2 lasts one extra clock, then state 4 chooses read, write or read-modify-write.
// - a read or write ends by releasing the strobe for one precharge clock, restoring row address and dropping cycle_sync.
// - a read-modify-write keeps the strobe until size_acknowledge and write strobe have both been seen.
// - the data-sizing chip is told of a processor cycle only through cycle_sync, which stays low otherwise.
`timescale 1ns/100ps
`default_nettype none

module dta_timing_arbiter
#(
	parameter int BANKS  = dta_pkg::DTA_BANKS,
	parameter int BANK_W = dta_pkg::DTA_BANK_W
)
(
	// clock and reset
	input  wire logic                  i_clock,
	input  wire logic                  i_rst,
	// processor side
	input  wire logic                  i_memory_request,
	input  wire logic [BANK_W-1:0]     i_bank_select,
	input  wire logic                  i_rmw_cycle_indicator,
	// refresh timer
	input  wire logic                  i_refresh_request,
	// data-sizing chip
	input  wire logic                  i_size_acknowledge,
	input  wire logic                  i_write_strobe,
	// memory array control
	output var  dta_pkg::dta_dram_ctl_t o_dram,
	// status
	output var  logic                  o_busy,
	output var  logic                  o_refresh_pending
);

	dta_pkg::dta_state_t    state_reg;
	dta_pkg::dta_state_t    state_next;
	logic [BANK_W-1:0]      bank_reg;
	logic [BANK_W-1:0]      bank_next;
	logic                   ack_seen_reg;
	logic                   ack_seen_next;
	logic                   we_seen_reg;
	logic                   we_seen_next;
	dta_pkg::dta_dram_ctl_t ctl_reg;
	dta_pkg::dta_dram_ctl_t ctl_next;
	logic                   pending;
	logic                   refresh_taken;

	// one-hot bank decode
	function automatic logic [BANKS-1:0] bank_onehot(
		input logic [BANK_W-1:0] bank);
		logic [BANKS-1:0] hot;
		hot = '0;
		hot[bank] = 1'h1;
		return hot;
	endfunction

	// control lines that belong to each state
	function automatic dta_pkg::dta_dram_ctl_t ctl_for(
		input dta_pkg::dta_state_t st,
		input logic [BANK_W-1:0]   bank);
		dta_pkg::dta_dram_ctl_t c;
		c = dta_pkg::DTA_CTL_RESET;
		unique case (st)
			dta_pkg::DTA_IDLE,
			dta_pkg::DTA_PRECHARGE,
			dta_pkg::DTA_REF_END:
				c = dta_pkg::DTA_CTL_RESET;
			dta_pkg::DTA_ROW:
				c.row_strobe = bank_onehot(bank);
			dta_pkg::DTA_COL,
			dta_pkg::DTA_COL_HOLD,
			dta_pkg::DTA_ACCESS,
			dta_pkg::DTA_RMW_WAIT:
			begin
				c.row_strobe            = bank_onehot(bank);
				c.row_address_enable    = 1'h0;
				c.column_address_enable = 1'h1;
				c.cycle_sync            = 1'h1;
			end
			dta_pkg::DTA_REF_ADDR:
			begin
				c.row_address_enable     = 1'h0;
				c.refresh_address_select = 1'h1;
			end
			dta_pkg::DTA_REF_STROBE:
			begin
				c.row_address_enable     = 1'h0;
				c.refresh_address_select = 1'h1;
				c.row_strobe             = '1;
			end
		endcase
		return c;
	endfunction

	dta_refresh_flag u_refresh_flag
	(
		.i_clock               (i_clock),
		.i_rst                 (i_rst),
		.i_refresh_request     (i_refresh_request),
		.i_refresh_taken       (refresh_taken),
		.o_refresh_pending_flag(pending)
	);

	// the flag clears as the refresh cycle is entered
	assign refresh_taken = (state_reg == dta_pkg::DTA_IDLE)
		&& pending;

	always_comb
	begin
		state_next    = state_reg;
		bank_next     = bank_reg;
		ack_seen_next = ack_seen_reg;
		we_seen_next  = we_seen_reg;
		unique case (state_reg)
			dta_pkg::DTA_IDLE:
			begin
				ack_seen_next = 1'h0;
				we_seen_next  = 1'h0;
				// only idle arbitrates; a busy cycle is never preempted
				if (pending)
					state_next = dta_pkg::DTA_REF_ADDR;
				else if (i_memory_request)
				begin
					state_next = dta_pkg::DTA_ROW;
					bank_next  = i_bank_select;
				end
			end
			dta_pkg::DTA_ROW:
				state_next = dta_pkg::DTA_COL;
			dta_pkg::DTA_COL:
				state_next = dta_pkg::DTA_COL_HOLD;
			dta_pkg::DTA_COL_HOLD:
				state_next = dta_pkg::DTA_ACCESS;
			dta_pkg::DTA_ACCESS:
			begin
				if (i_rmw_cycle_indicator)
					state_next = dta_pkg::DTA_RMW_WAIT;
				else
					state_next = dta_pkg::DTA_PRECHARGE;
			end
			dta_pkg::DTA_RMW_WAIT:
			begin
				// the acknowledge of the read half also counts; the
				// sizing chip raises the write strobe no earlier than it
				if (i_size_acknowledge)
					ack_seen_next = 1'h1;
				if (i_write_strobe)
					we_seen_next = 1'h1;
				if ((ack_seen_reg || i_size_acknowledge)
					&& (we_seen_reg || i_write_strobe))
					state_next = dta_pkg::DTA_PRECHARGE;
			end
			dta_pkg::DTA_PRECHARGE:
				state_next = dta_pkg::DTA_IDLE;
			dta_pkg::DTA_REF_ADDR:
				state_next = dta_pkg::DTA_REF_STROBE;
			dta_pkg::DTA_REF_STROBE:
				state_next = dta_pkg::DTA_REF_END;
			dta_pkg::DTA_REF_END:
				state_next = dta_pkg::DTA_IDLE;
			default:
				state_next = dta_pkg::DTA_IDLE;
		endcase
		// outputs are registered against the state being entered
		ctl_next = ctl_for(state_next, bank_next);
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			state_reg    <= dta_pkg::DTA_IDLE;
			bank_reg     <= '0;
			ack_seen_reg <= 1'h0;
			we_seen_reg  <= 1'h0;
			ctl_reg      <= dta_pkg::DTA_CTL_RESET;
		end
		else
		begin
			state_reg    <= state_next;
			bank_reg     <= bank_next;
			ack_seen_reg <= ack_seen_next;
			we_seen_reg  <= we_seen_next;
			ctl_reg      <= ctl_next;
		end
	end

	assign o_dram            = ctl_reg;
	assign o_busy            = (state_reg != dta_pkg::DTA_IDLE);
	assign o_refresh_pending = pending;

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_rst);

	localparam logic [BANKS-1:0] NO_STROBE = '0;

	a_refresh_beats_request: assert property (
		state_reg == dta_pkg::DTA_IDLE && pending && i_memory_request
		|=> state_reg == dta_pkg::DTA_REF_ADDR)
		else $error("refresh did not win over processor request");

	a_busy_no_arbitrate: assert property (
		state_reg != dta_pkg::DTA_IDLE && i_refresh_request
		|=> pending && state_reg != dta_pkg::DTA_REF_ADDR)
		else $error("refresh request lost or serviced mid-cycle");

	a_flag_holds_until: assert property (
		pending && state_reg != dta_pkg::DTA_IDLE |=> pending)
		else $error("pending refresh flag dropped before service");

	a_flag_clears: assert property (
		state_reg == dta_pkg::DTA_IDLE && pending && !i_refresh_request
		|=> !pending)
		else $error("pending refresh flag not cleared on service");

	a_refresh_select_span: assert property (
		state_reg == dta_pkg::DTA_REF_ADDR
		|-> o_dram.refresh_address_select
		##1 o_dram.refresh_address_select ##1 !o_dram.refresh_address_select)
		else $error("refresh select not held over refresh cycle");

	a_refresh_strobe_all: assert property (
		state_reg == dta_pkg::DTA_REF_ADDR
		|-> !o_dram.row_address_enable && o_dram.row_strobe == NO_STROBE
		##1 o_dram.row_strobe == '1 ##1 o_dram.row_strobe == NO_STROBE)
		else $error("refresh strobe sequence wrong");

	a_processor_start: assert property (
		state_reg == dta_pkg::DTA_IDLE && !pending && i_memory_request
		|=> state_reg == dta_pkg::DTA_ROW)
		else $error("processor cycle did not start");

	a_idle_polls: assert property (
		state_reg == dta_pkg::DTA_IDLE && !pending && !i_memory_request
		|=> state_reg == dta_pkg::DTA_IDLE)
		else $error("left idle with nothing requested");

	a_one_bank: assert property (
		state_reg == dta_pkg::DTA_IDLE && !pending && i_memory_request
		|=> o_dram.row_strobe == bank_onehot($past(i_bank_select)))
		else $error("wrong bank strobed");

	a_column_phase: assert property (
		state_reg == dta_pkg::DTA_ROW
		|=> o_dram.column_address_enable && !o_dram.row_address_enable
		&& o_dram.cycle_sync)
		else $error("column phase lines wrong");

	a_col_extra_clock: assert property (
		state_reg == dta_pkg::DTA_COL
		|=> state_reg == dta_pkg::DTA_COL_HOLD
		##1 state_reg == dta_pkg::DTA_ACCESS)
		else $error("state 2 not held one extra clock");

	a_precharge_end: assert property (
		state_reg == dta_pkg::DTA_ACCESS && !i_rmw_cycle_indicator
		|=> o_dram.row_strobe == NO_STROBE && o_dram.row_address_enable
		&& !o_dram.cycle_sync ##1 state_reg == dta_pkg::DTA_IDLE)
		else $error("read or write ending wrong");

	a_rmw_holds_strobe: assert property (
		state_reg == dta_pkg::DTA_RMW_WAIT
		&& !((ack_seen_reg || i_size_acknowledge)
		&& (we_seen_reg || i_write_strobe))
		|=> o_dram.row_strobe != NO_STROBE)
		else $error("strobe released before both answers");

	a_sync_only_cpu: assert property (
		o_dram.cycle_sync |-> state_reg inside {dta_pkg::DTA_COL,
		dta_pkg::DTA_COL_HOLD, dta_pkg::DTA_ACCESS, dta_pkg::DTA_RMW_WAIT})
		else $error("cycle sync outside a processor cycle");

	a_reset_state: assert property (
		$past(i_rst) |-> state_reg == dta_pkg::DTA_IDLE && !pending
		&& o_dram == dta_pkg::DTA_CTL_RESET)
		else $error("reset values wrong");

	c_read_write: cover property (
		state_reg == dta_pkg::DTA_ACCESS && !i_rmw_cycle_indicator);
	c_rmw: cover property (
		state_reg == dta_pkg::DTA_RMW_WAIT ##1
		state_reg == dta_pkg::DTA_PRECHARGE);
	c_refresh: cover property (state_reg == dta_pkg::DTA_REF_STROBE);
	c_refresh_mid_cycle: cover property (
		state_reg == dta_pkg::DTA_COL && i_refresh_request);

endmodule

`default_nettype wire

// file: dta_sizing_model.sv
// data-sizing chip stand-in: acknowledge and write strobe during a cycle
// assumes cycle_sync from the arbiter marks each processor cycle
`timescale 1ns/100ps
`default_nettype none

module dta_sizing_model
(
	// clock and reset
	input  wire logic       i_clock,
	input  wire logic       i_rst,
	// arbiter side
	input  wire logic       i_cycle_sync,
	input  wire logic       i_rmw,
	input  wire logic [3:0] i_delay,
	// answers
	output var  logic       o_size_acknowledge,
	output var  logic       o_write_strobe
);
	logic [3:0] cnt_reg;
	logic [3:0] cnt_next;

	// lines stay low outside a cycle, so a stale answer cannot leak
	always_comb
	begin
		cnt_next = i_cycle_sync ? cnt_reg + 4'h1 : 4'h0;
		o_size_acknowledge = i_cycle_sync && cnt_reg >= 4'h3;
		o_write_strobe = i_cycle_sync && i_rmw && cnt_reg >= i_delay;
	end

	always_ff @(posedge i_clock)
		cnt_reg <= i_rst ? 4'h0 : cnt_next;
endmodule

`default_nettype wire

// file: tb_top.sv
// testbench: random processor and refresh cycles checked cycle by cycle
// assumes the sizing-chip model answers on the far side
`timescale 1ns/100ps
`default_nettype none

module tb_top;
	logic                   i_clock;
	logic                   i_rst;
	logic                   i_memory_request;
	logic [1:0]             i_bank_select;
	logic                   i_rmw_cycle_indicator;
	logic                   i_refresh_request;
	logic                   i_size_acknowledge;
	logic                   i_write_strobe;
	dta_pkg::dta_dram_ctl_t o_dram;
	logic                   o_busy;
	logic                   o_refresh_pending;
	logic [3:0]             ws_dly;
	logic                   exp_pend;
	int                     err_count;
	int                     n_compared;
	logic [dta_pkg::DTA_REFRESH_ROW_W-1:0] row_cnt = '0;
	logic [dta_pkg::DTA_REFRESH_ROW_W-1:0] exp_rows = '0;
	logic                   sel_q = 1'b0;

	dta_timing_arbiter dut (.i_clock(i_clock), .i_rst(i_rst),
		.i_memory_request(i_memory_request), .i_bank_select(i_bank_select),
		.i_rmw_cycle_indicator(i_rmw_cycle_indicator),
		.i_refresh_request(i_refresh_request),
		.i_size_acknowledge(i_size_acknowledge),
		.i_write_strobe(i_write_strobe), .o_dram(o_dram), .o_busy(o_busy),
		.o_refresh_pending(o_refresh_pending));

	dta_sizing_model partner (.i_clock(i_clock), .i_rst(i_rst),
		.i_cycle_sync(o_dram.cycle_sync), .i_rmw(i_rmw_cycle_indicator),
		.i_delay(ws_dly), .o_size_acknowledge(i_size_acknowledge),
		.o_write_strobe(i_write_strobe));

	// outside refresh row counter: steps on each fall of the refresh select
	always @(posedge i_clock)
	begin
		sel_q <= o_dram.refresh_address_select;
		if (sel_q && !o_dram.refresh_address_select)
			row_cnt <= row_cnt + 1'b1;
	end

	initial
	begin
		i_clock = 1'b0;
		forever #2 i_clock = ~i_clock;
	end

	// k: 0 idle, 1 row, 2 column, 3 refresh address, 4 refresh strobe
	function automatic dta_pkg::dta_dram_ctl_t ctl(input int k,
		input logic [1:0] b);
		dta_pkg::dta_dram_ctl_t c;
		c = '0;
		c.row_address_enable = (k == 0 || k == 1);
		c.column_address_enable = (k == 2);
		c.cycle_sync = (k == 2);
		c.refresh_address_select = (k >= 3);
		if (k == 1 || k == 2)
			c.row_strobe = 4'h1 << b;
		if (k == 4)
			c.row_strobe = 4'hf;
		return c;
	endfunction

	task automatic tally_and_finish();
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// one cycle: drop any refresh pulse, then compare all outputs
	task automatic step(input dta_pkg::dta_dram_ctl_t e, input logic bz);
		logic pulsed;
		pulsed = i_refresh_request;
		@(negedge i_clock);
		if (pulsed)
		begin
			i_refresh_request = 1'b0;
			exp_pend = 1'b1;
		end
		n_compared++;
		if ({o_dram, o_busy, o_refresh_pending} !== {e, bz, exp_pend})
		begin
			err_count++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time,
				{e, bz, exp_pend}, {o_dram, o_busy, o_refresh_pending});
		end
	endtask

	task automatic ref_walk();
		exp_pend = 1'b0;
		step(ctl(3, 2'h0), 1'b1);
		step(ctl(4, 2'h0), 1'b1);
		step(ctl(0, 2'h0), 1'b1);
		step(ctl(0, 2'h0), 1'b0);
		exp_rows++;
		n_compared++;
		if (row_cnt !== exp_rows)
		begin
			err_count++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, exp_rows,
				row_cnt);
		end
	endtask

	task automatic do_reset(input int n);
		i_rst = 1'b1;
		exp_pend = 1'b0;
		repeat (n) step(ctl(0, 2'h0), 1'b0);
		i_rst = 1'b0;
	endtask

	// rf 1..3 pulses a refresh request inside the cycle
	task automatic proc(input logic [1:0] b, input logic rmw, input int rf);
		logic a;
		logic w;
		i_memory_request = 1'b1;
		i_bank_select = b;
		i_rmw_cycle_indicator = rmw;
		step(ctl(1, b), 1'b1);
		i_memory_request = 1'b0;
		if (rf == 1)
			i_refresh_request = 1'b1;
		step(ctl(2, b), 1'b1);
		if (rf == 2)
			i_refresh_request = 1'b1;
		step(ctl(2, b), 1'b1);
		if (rf == 3)
			i_refresh_request = 1'b1;
		step(ctl(2, b), 1'b1);
		a = i_size_acknowledge;
		w = i_write_strobe;
		for (int n = 0; rmw && n < 16 && !(a && w); n++)
		begin
			step(ctl(2, b), 1'b1);
			a |= i_size_acknowledge;
			w |= i_write_strobe;
		end
		step(ctl(0, b), 1'b1);
		i_memory_request = exp_pend;
		step(ctl(0, b), 1'b0);
		if (exp_pend)
			ref_walk();
	endtask

	initial
	begin
		i_memory_request = 1'b0;
		i_bank_select = 2'h0;
		i_rmw_cycle_indicator = 1'b0;
		i_refresh_request = 1'b0;
		ws_dly = 4'h3;
		exp_pend = 1'b0;
		err_count = 0;
		n_compared = 0;
		void'($urandom(32'h98fd33f2));
		do_reset(8);
		i_refresh_request = 1'b1;
		step(ctl(0, 2'h0), 1'b0);
		ref_walk();
		repeat (3) step(ctl(0, 2'h0), 1'b0);
		// back-to-back through every bank, then one read-modify-write each
		for (int b = 0; b < 4; b++)
			proc(2'(b), 1'b0, 0);
		for (int b = 0; b < 4; b++)
		begin
			ws_dly = 4'(3 + 2 * b);
			proc(2'(b), 1'b1, b);
		end
		for (int i = 0; i < 60; i++)
		begin
			ws_dly = 4'h3 + 4'($urandom % 5);
			proc(2'($urandom), 1'($urandom), int'($urandom % 6));
			if (!i_memory_request)
				repeat ($urandom % 3) step(ctl(0, 2'h0), 1'b0);
		end
		if (i_memory_request)
			proc(2'h2, 1'b1, 0);
		// reset in mid-cycle with a refresh pending
		i_memory_request = 1'b1;
		i_bank_select = 2'h3;
		step(ctl(1, 2'h3), 1'b1);
		i_memory_request = 1'b0;
		i_refresh_request = 1'b1;
		step(ctl(2, 2'h3), 1'b1);
		do_reset(2);
		proc(2'h1, 1'b1, 0);
		tally_and_finish();
	end

	initial
	begin
		#100000;
		err_count++;
		tally_and_finish();
	end
endmodule

`default_nettype wire
